// [irqwk_top.sv]
// interrupt request, enable, vectoring and wake-up logic
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns

module irqwk_top (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        nvm_write_done,
  input  wire logic        timer_match_a,
  input  wire logic        timer_match_p,
  input  wire logic        sleep_req,
  input  wire logic        stack_full,
  input  wire logic        core_ready,
  input  wire logic        return_and_reenable,
  input  wire logic        plain_return,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  output logic             irq_call,
  output logic      [1:0]  irq_vector,
  output logic             push_pc,
  output logic             pop_pc,
  output logic             osc_enable,
  output logic             core_run,
  output logic             status_irq
);

  // ==========================================================================
  // state
  // ==========================================================================
  logic                      global_irq_enable_r;
  logic                      nvm_write_irq_enable_r;
  logic                      merged_irq_enable_r;
  logic                      tma_enable_r;
  logic                      tmp_enable_r;
  logic                      nvm_write_done_flag_r;
  logic                      merged_irq_flag_r;
  logic                      tma_flag_r;
  logic                      tmp_flag_r;
  logic [irqwk_pkg::NUM_ST-1:0] st_stat_r;
  logic [irqwk_pkg::NUM_ST-1:0] st_en_r;
  irqwk_pkg::irqwk_pwr_type  pwr_r;
  irqwk_pkg::irqwk_pwr_type  pwr_nxt;
  logic                      call_busy_r;

  // pin synchronisers
  logic [1:0] nvm_s_r;
  logic [1:0] ta_s_r;
  logic [1:0] tp_s_r;
  logic [1:0] slp_s_r;
  logic       nvm_d_r;
  logic       ta_d_r;
  logic       tp_d_r;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      nvm_s_r <= 2'h0;
      ta_s_r  <= 2'h0;
      tp_s_r  <= 2'h0;
      slp_s_r <= 2'h0;
      nvm_d_r <= 1'b0;
      ta_d_r  <= 1'b0;
      tp_d_r  <= 1'b0;
    end else begin
      nvm_s_r <= {nvm_s_r[0], nvm_write_done};
      ta_s_r  <= {ta_s_r[0], timer_match_a};
      tp_s_r  <= {tp_s_r[0], timer_match_p};
      slp_s_r <= {slp_s_r[0], sleep_req};
      nvm_d_r <= nvm_s_r[1];
      ta_d_r  <= ta_s_r[1];
      tp_d_r  <= tp_s_r[1];
    end
  end

  logic nvm_ev;
  logic ta_ev;
  logic tp_ev;
  assign nvm_ev = nvm_s_r[1] & ~nvm_d_r;
  assign ta_ev  = ta_s_r[1] & ~ta_d_r;
  assign tp_ev  = tp_s_r[1] & ~tp_d_r;

  // ==========================================================================
  // register writes
  // ==========================================================================
  logic wr_ctrl;
  logic wr_flags;
  logic wr_stclr;
  logic wr_sten;
  assign wr_ctrl  = reg_wr & (reg_addr == irqwk_pkg::ADDR_CTRL);
  assign wr_flags = reg_wr & (reg_addr == irqwk_pkg::ADDR_FLAGS);
  assign wr_stclr = reg_wr & (reg_addr == irqwk_pkg::ADDR_ST_CLR);
  assign wr_sten  = reg_wr & (reg_addr == irqwk_pkg::ADDR_ST_EN);

  // ==========================================================================
  // arbitration
  // ==========================================================================
  logic nvm_go;
  logic mrg_go;
  logic take;
  assign nvm_go = global_irq_enable_r & nvm_write_irq_enable_r
                  & nvm_write_done_flag_r;
  assign mrg_go = global_irq_enable_r & merged_irq_enable_r
                  & merged_irq_flag_r
                  & ((tma_flag_r & tma_enable_r)
                     | (tmp_flag_r & tmp_enable_r));
  // stack full blocks acknowledge; one call in flight at a time
  assign take = (nvm_go | mrg_go) & ~stack_full & core_ready
                & ~call_busy_r & (pwr_r == irqwk_pkg::IRQWK_RUN);
  logic take_nvm;
  logic take_mrg;
  assign take_nvm = take & nvm_go;
  assign take_mrg = take & ~nvm_go;

  // ==========================================================================
  // enables
  // ==========================================================================
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      global_irq_enable_r <= 1'b0;
    end else if (take) begin
      global_irq_enable_r <= 1'b0;
    end else if (return_and_reenable) begin
      global_irq_enable_r <= 1'b1;
    end else if (wr_ctrl) begin
      global_irq_enable_r <= reg_wdata[irqwk_pkg::CTRL_GIE];
    end
    // plain return leaves the enable as it stands
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      nvm_write_irq_enable_r <= 1'b0;
      merged_irq_enable_r    <= 1'b0;
      tma_enable_r           <= 1'b0;
      tmp_enable_r           <= 1'b0;
    end else if (wr_ctrl) begin
      nvm_write_irq_enable_r <= reg_wdata[irqwk_pkg::CTRL_NVM_EN];
      merged_irq_enable_r    <= reg_wdata[irqwk_pkg::CTRL_MRG_EN];
      tma_enable_r           <= reg_wdata[irqwk_pkg::CTRL_TA_EN];
      tmp_enable_r           <= reg_wdata[irqwk_pkg::CTRL_TP_EN];
    end
  end

  // ==========================================================================
  // request flags: set wins over clear, enables never clear them
  // ==========================================================================
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      nvm_write_done_flag_r <= 1'b0;
    end else if (nvm_ev) begin
      nvm_write_done_flag_r <= 1'b1;
    end else if (take_nvm
                 | (wr_flags & reg_wdata[irqwk_pkg::FLG_NVM])) begin
      nvm_write_done_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      merged_irq_flag_r <= 1'b0;
    end else if (ta_ev | tp_ev) begin
      merged_irq_flag_r <= 1'b1;
    end else if (take_mrg
                 | (wr_flags & reg_wdata[irqwk_pkg::FLG_MRG])) begin
      merged_irq_flag_r <= 1'b0;
    end
  end

  // timer flags are cleared only by software
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tma_flag_r <= 1'b0;
      tmp_flag_r <= 1'b0;
    end else begin
      if (ta_ev) begin
        tma_flag_r <= 1'b1;
      end else if (wr_flags & reg_wdata[irqwk_pkg::FLG_TA]) begin
        tma_flag_r <= 1'b0;
      end
      if (tp_ev) begin
        tmp_flag_r <= 1'b1;
      end else if (wr_flags & reg_wdata[irqwk_pkg::FLG_TP]) begin
        tmp_flag_r <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // call sequencing toward the core
  // ==========================================================================
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_call    <= 1'b0;
      irq_vector  <= irqwk_pkg::VEC_NONE;
      push_pc     <= 1'b0;
      call_busy_r <= 1'b0;
    end else begin
      irq_call    <= take;
      push_pc     <= take;
      call_busy_r <= take;
      if (take) begin
        irq_vector <= take_nvm ? irqwk_pkg::VEC_NVM : irqwk_pkg::VEC_MERGED;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pop_pc <= 1'b0;
    end else begin
      pop_pc <= return_and_reenable | plain_return;
    end
  end

  // ==========================================================================
  // sleep and wake-up
  // ==========================================================================
  logic [irqwk_pkg::NUM_FLAGS-1:0] flag_vec;
  logic [irqwk_pkg::NUM_FLAGS-1:0] rise_vec;
  logic                            armed;
  assign flag_vec = {tmp_flag_r, tma_flag_r, merged_irq_flag_r, nvm_write_done_flag_r};
  assign armed    = (pwr_r == irqwk_pkg::IRQWK_SLEEP);

  genvar gi;
  generate
    for (gi = 0; gi < irqwk_pkg::NUM_FLAGS; gi = gi + 1) begin : g_edge
      irqwk_edge u_edge (
        .ref_clk (ref_clk),
        .rst     (rst),
        .arm     (armed),
        .flag    (flag_vec[gi]),
        .rise    (rise_vec[gi])
      );
    end
  endgenerate

  logic wake;
  assign wake = |rise_vec;

  always_comb begin
    pwr_nxt = pwr_r;
    unique case (pwr_r)
      irqwk_pkg::IRQWK_RUN: begin
        if (slp_s_r[1]) begin
          pwr_nxt = irqwk_pkg::IRQWK_SLEEP;
        end
      end
      irqwk_pkg::IRQWK_SLEEP: begin
        if (wake) begin
          pwr_nxt = irqwk_pkg::IRQWK_WAKE;
        end
      end
      irqwk_pkg::IRQWK_WAKE: begin
        if (~slp_s_r[1]) begin
          pwr_nxt = irqwk_pkg::IRQWK_RUN;
        end
      end
      default: begin
        pwr_nxt = irqwk_pkg::IRQWK_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pwr_r      <= irqwk_pkg::IRQWK_RUN;
      osc_enable <= 1'b1;
      core_run   <= 1'b1;
    end else begin
      pwr_r      <= pwr_nxt;
      // edge logic runs on this free clock; only the system oscillator stops
      osc_enable <= (pwr_nxt != irqwk_pkg::IRQWK_SLEEP);
      core_run   <= (pwr_nxt == irqwk_pkg::IRQWK_RUN);
    end
  end

  // ==========================================================================
  // interrupt status, clear and enable
  // ==========================================================================
  logic [irqwk_pkg::NUM_ST-1:0] st_set;
  assign st_set = {stack_full & (nvm_go | mrg_go), take, wake};

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_stat_r <= '0;
    end else begin
      st_stat_r <= st_set
                   | (st_stat_r & ~({irqwk_pkg::NUM_ST{wr_stclr}}
                                    & reg_wdata[irqwk_pkg::NUM_ST-1:0]));
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_en_r <= '0;
    end else if (wr_sten) begin
      st_en_r <= reg_wdata[irqwk_pkg::NUM_ST-1:0];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      status_irq <= 1'b0;
    end else begin
      status_irq <= |(st_stat_r & st_en_r);
    end
  end

  // ==========================================================================
  // register reads
  // ==========================================================================
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= irqwk_pkg::RESET_BYTE;
    end else if (reg_rd) begin
      unique case (reg_addr)
        irqwk_pkg::ADDR_CTRL: begin
          reg_rdata <= {3'h0, tmp_enable_r, tma_enable_r, merged_irq_enable_r,
                        nvm_write_irq_enable_r, global_irq_enable_r};
        end
        irqwk_pkg::ADDR_FLAGS: begin
          reg_rdata <= {4'h0, flag_vec};
        end
        irqwk_pkg::ADDR_ST_STAT: begin
          reg_rdata <= {5'h0, st_stat_r};
        end
        irqwk_pkg::ADDR_ST_EN: begin
          reg_rdata <= {5'h0, st_en_r};
        end
        default: begin
          reg_rdata <= irqwk_pkg::RESET_BYTE;
        end
      endcase
    end else begin
      reg_rdata <= irqwk_pkg::RESET_BYTE;
    end
  end

endmodule

// [irqwk_pkg.sv]
// package: constants and types for the interrupt request and wake-up logic
package irqwk_pkg;

  // vector numbers, lower index wins when several are pending
  localparam int unsigned VEC_W        = 2;
  localparam logic [1:0]  VEC_NVM      = 2'h0;
  localparam logic [1:0]  VEC_MERGED   = 2'h1;
  localparam logic [1:0]  VEC_NONE     = 2'h3;

  // control register offsets
  localparam int unsigned ADDR_W       = 4;
  localparam logic [3:0]  ADDR_CTRL    = 4'h0;
  localparam logic [3:0]  ADDR_FLAGS   = 4'h1;
  localparam logic [3:0]  ADDR_ST_STAT = 4'h2;
  localparam logic [3:0]  ADDR_ST_CLR  = 4'h3;
  localparam logic [3:0]  ADDR_ST_EN   = 4'h4;
  localparam int unsigned DATA_W       = 8;

  // control register fields
  localparam int unsigned CTRL_GIE     = 0;
  localparam int unsigned CTRL_NVM_EN  = 1;
  localparam int unsigned CTRL_MRG_EN  = 2;
  localparam int unsigned CTRL_TA_EN   = 3;
  localparam int unsigned CTRL_TP_EN   = 4;

  // flag register fields (write 1 to clear)
  localparam int unsigned FLG_NVM      = 0;
  localparam int unsigned FLG_MRG      = 1;
  localparam int unsigned FLG_TA       = 2;
  localparam int unsigned FLG_TP       = 3;
  localparam int unsigned NUM_FLAGS    = 4;

  // interrupt status fields
  localparam int unsigned ST_WAKE      = 0;
  localparam int unsigned ST_ENTRY     = 1;
  localparam int unsigned ST_STK_BLK   = 2;
  localparam int unsigned NUM_ST       = 3;

  localparam logic [7:0]  RESET_BYTE   = 8'h00;

  typedef enum logic [2:0] {
    IRQWK_RUN   = 3'b001,
    IRQWK_SLEEP = 3'b010,
    IRQWK_WAKE  = 3'b100
  } irqwk_pwr_type;

endpackage

// [irqwk_edge.sv]
// rising edge detector with a sampling gate for one request flag
`timescale 1ns/1ns
module irqwk_edge (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic arm,
  input  wire logic flag,
  output logic      rise
);
  logic prev_r;

  // prev follows the flag, so a flag high on entry never rises
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= flag;
    end
  end

  // no register on the output: the caller registers it
  assign rise = arm & flag & ~prev_r;
endmodule

// [irqwk_core_model.sv]
// partner model: core program sequencer and its return stack depth
`timescale 1ns/1ns
module irqwk_core_model #(
  parameter int DEPTH = 1
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic push_pc,
  input  wire logic pop_pc,
  input  wire logic slow,
  output logic      stack_full,
  output logic      core_ready
);
  int depth_r;

  // one slot per call: only the program counter goes on the stack
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      depth_r <= 0;
    end else begin
      depth_r <= depth_r + int'(push_pc) - int'(pop_pc && depth_r > 0);
    end
  end

  assign stack_full = (depth_r >= DEPTH);

  // a slow core accepts a call only every other cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      core_ready <= 1'b1;
    end else begin
      core_ready <= slow ? !core_ready : 1'b1;
    end
  end
endmodule

// [irqwk_top_sva.sv]
// checker: port-level properties of the interrupt request and wake-up logic
`timescale 1ns/1ns
module irqwk_top_sva (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       stack_full,
  input wire logic       return_and_reenable,
  input wire logic       plain_return,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       irq_call,
  input wire logic [1:0] irq_vector,
  input wire logic       push_pc,
  input wire logic       pop_pc,
  input wire logic       osc_enable,
  input wire logic       core_run
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // ==========================================
  // sequences
  sequence return_s;
    return_and_reenable || plain_return;
  endsequence
  sequence quiet_s;
    (!return_and_reenable && !reg_wr)[*3];
  endsequence

  // ==========================================
  // properties
  call_pulse_a: assert property (irq_call |=> !irq_call)
    else $error("call longer than one cycle");
  push_only_a: assert property (push_pc == irq_call)
    else $error("push not paired with call");
  stack_block_a: assert property (stack_full |=> !irq_call)
    else $error("call with stack full");
  pop_after_a: assert property (return_s |=> pop_pc)
    else $error("return without pop");
  pop_cause_a: assert property (pop_pc |-> $past(return_and_reenable)
                                || $past(plain_return))
    else $error("pop without return");
  vec_valid_a: assert property (irq_call |-> irq_vector != irqwk_pkg::VEC_NONE)
    else $error("call to no vector");
  vec_hold_a: assert property (!irq_call ##1 !irq_call |-> $stable(irq_vector))
    else $error("vector moved without call");
  gie_clear_a: assert property (irq_call ##0 quiet_s |=> !irq_call)
    else $error("call with global enable cleared");
  osc_off_a: assert property (!osc_enable |-> !core_run)
    else $error("core runs with oscillator off");
  sleep_call_a: assert property (!core_run |=> !irq_call)
    else $error("call while asleep");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data without read");
endmodule

bind irqwk_top irqwk_top_sva u_sva (.ref_clk, .rst, .stack_full, .return_and_reenable,
  .plain_return, .reg_wr, .reg_rd, .reg_rdata, .irq_call, .irq_vector, .push_pc, .pop_pc,
  .osc_enable, .core_run);

// [tb_interrupt_request_wakeup_logic.sv]
// testbench: interrupt request, enable, vectoring and wake-up logic
`timescale 1ns/1ns
module tb_interrupt_request_wakeup_logic;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [2:0]  pin = 3'h0;
  logic        sleep_req = 1'b0;
  logic        rtn_reenable = 1'b0;
  logic        rtn_plain = 1'b0;
  logic        slow = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        rd_q = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  reg_rdata;
  logic [1:0]  irq_vector;
  logic        irq_call, push_pc, pop_pc, osc_enable, core_run, status_irq;
  logic        stack_full, core_ready;
  wire  [2:0]  lv = {status_irq, core_run, osc_enable};
  logic [15:0] rq[$];
  logic [1:0]  vq[$];
  int          mismatches = 0;
  int          compares = 0;

  always #10 ref_clk = ~ref_clk;

  irqwk_top u_dut (.ref_clk, .rst, .nvm_write_done(pin[0]), .timer_match_a(pin[1]),
    .timer_match_p(pin[2]), .sleep_req, .stack_full, .core_ready,
    .return_and_reenable(rtn_reenable), .plain_return(rtn_plain), .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .irq_call, .irq_vector, .push_pc, .pop_pc, .osc_enable,
    .core_run, .status_irq);
  irqwk_core_model #(.DEPTH(1)) u_core (.ref_clk, .rst, .push_pc, .pop_pc, .slow,
    .stack_full, .core_ready);

  // ==========================================
  // tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (mismatches == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    rq.push_back({m, e});
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask
  task automatic pulse(input int i);
    @(posedge ref_clk);
    pin[i] <= 1'b1;
    tick(4);
    pin[i] <= 1'b0;
    tick(4);
  endtask
  task automatic leave_isr(input logic re);
    @(posedge ref_clk);
    rtn_reenable <= re;
    rtn_plain <= !re;
    @(posedge ref_clk);
    rtn_reenable <= 1'b0;
    rtn_plain <= 1'b0;
  endtask
  task automatic wq(input int n);
    for (int i = 0; i < 60 && vq.size() > n; i++) @(posedge ref_clk);
    tick(2);
  endtask
  task automatic wlev(input int k, input logic v);
    for (int i = 0; i < 40 && lv[k] !== v; i++) @(posedge ref_clk);
    chk(8'(lv[k]), 8'(v));
  endtask

  // ==========================================
  // watchers: read data and calls against the noted expectations
  always @(posedge ref_clk) begin
    if (rd_q && rq.size() > 0) begin
      chk(reg_rdata & rq[0][15:8], rq[0][7:0]);
      void'(rq.pop_front());
    end
    rd_q <= reg_rd;
  end
  always @(posedge ref_clk) begin
    if (irq_call === 1'b1) begin
      chk({6'h00, irq_vector}, vq.size() > 0 ? {6'h00, vq[0]} : 8'hFF);
      if (vq.size() > 0) void'(vq.pop_front());
    end
  end

  initial begin
    #200000;
    mismatches++;
    tally_and_finish();
  end

  // ==========================================
  // scenarios
  initial begin
    logic [7:0] d;
    void'($urandom(18452));
    tick(5);
    rst <= 1'b0;
    tick(1);
    chk({6'h00, irq_vector}, 8'h03);
    for (int a = 0; a < 16; a++) rd(4'(a), 8'hFF, 8'h00);
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      wr(irqwk_pkg::ADDR_CTRL, d);
      wr(4'hF, ~d);
      rd(irqwk_pkg::ADDR_CTRL, 8'h1F, d & 8'h1F);
    end
    wr(irqwk_pkg::ADDR_CTRL, 8'h00);
    pulse(0);
    rd(irqwk_pkg::ADDR_FLAGS, 8'h0F, 8'h01);
    wr(irqwk_pkg::ADDR_CTRL, 8'h01);
    tick(6);
    rd(irqwk_pkg::ADDR_FLAGS, 8'h0F, 8'h01);
    vq.push_back(irqwk_pkg::VEC_NVM);
    wr(irqwk_pkg::ADDR_CTRL, 8'h03);
    wq(0);
    // the stack holds one entry: every call is followed by a return
    leave_isr(1'b0);
    rd(irqwk_pkg::ADDR_CTRL, 8'h1F, 8'h02);
    rd(irqwk_pkg::ADDR_FLAGS, 8'h0F, 8'h00);
    for (int i = 1; i < 3; i++) begin
      pulse(i);
      rd(irqwk_pkg::ADDR_FLAGS, 8'h0F, 8'h02 | (8'h02 << i));
      wr(irqwk_pkg::ADDR_CTRL, 8'h01 | (8'h04 << i));
      tick(6);
      vq.push_back(irqwk_pkg::VEC_MERGED);
      wr(irqwk_pkg::ADDR_CTRL, 8'h05 | (8'h04 << i));
      wq(0);
      leave_isr(1'b0);
      rd(irqwk_pkg::ADDR_FLAGS, 8'h0F, 8'h02 << i);
      wr(irqwk_pkg::ADDR_FLAGS, 8'h0F);
    end
    slow <= 1'($urandom);
    pulse(0);
    pulse(1);
    vq.push_back(irqwk_pkg::VEC_NVM);
    vq.push_back(irqwk_pkg::VEC_MERGED);
    wr(irqwk_pkg::ADDR_CTRL, 8'h0F);
    wq(1);
    leave_isr(1'b1);
    wq(0);
    leave_isr(1'b0);
    rd(irqwk_pkg::ADDR_CTRL, 8'h01, 8'h00);
    rd(irqwk_pkg::ADDR_FLAGS, 8'h0F, 8'h04);
    slow <= 1'b0;
    wr(irqwk_pkg::ADDR_ST_CLR, 8'h04);
    pulse(0);
    vq.push_back(irqwk_pkg::VEC_NVM);
    wr(irqwk_pkg::ADDR_CTRL, 8'h03);
    wq(0);
    pulse(0);
    wr(irqwk_pkg::ADDR_CTRL, 8'h03);
    tick(8);
    rd(irqwk_pkg::ADDR_ST_STAT, 8'h04, 8'h04);
    vq.push_back(irqwk_pkg::VEC_NVM);
    leave_isr(1'b0);
    wq(0);
    leave_isr(1'b0);
    wr(irqwk_pkg::ADDR_CTRL, 8'h00);
    wr(irqwk_pkg::ADDR_FLAGS, 8'h0F);
    pulse(1);
    sleep_req <= 1'b1;
    wlev(0, 1'b0);
    pulse(1);
    tick(6);
    chk(8'(osc_enable), 8'h00);
    pulse(0);
    wlev(0, 1'b1);
    sleep_req <= 1'b0;
    wlev(1, 1'b1);
    rd(irqwk_pkg::ADDR_ST_STAT, 8'h07, 8'h07);
    wr(irqwk_pkg::ADDR_ST_CLR, 8'h06);
    wr(irqwk_pkg::ADDR_ST_EN, 8'h01);
    wlev(2, 1'b1);
    wr(irqwk_pkg::ADDR_ST_EN, 8'h00);
    wlev(2, 1'b0);
    wr(irqwk_pkg::ADDR_ST_EN, 8'h01);
    wr(irqwk_pkg::ADDR_ST_CLR, 8'h01);
    wlev(2, 1'b0);
    rd(irqwk_pkg::ADDR_ST_STAT, 8'h07, 8'h00);
    rd(irqwk_pkg::ADDR_ST_EN, 8'hFF, 8'h01);
    tick(4);
    chk(8'(vq.size()), 8'h00);
    tally_and_finish();
  end
endmodule
